/* cs_calendar_supervision.sv */
/*
 * Calendar readout and supervision: calendar words from the keypad clock,
 * activation, correction and refresh-timeout warnings, time operations,
 * Wishbone register slave and a masked level interrupt.
 * Assumes all keypad inputs are synchronous to CLK_IN.
 */
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module cs_calendar_supervision
	import cs_pkg::*;
#(
	parameter int unsigned TICK_CYC      = TICK_CYCLES,
	parameter int unsigned STARTUP_LIMIT = STARTUP_TICKS,
	parameter int unsigned ABSENT_LIMIT  = ABSENT_TICKS
) (
	input  wire logic        CLK_IN,
	input  wire logic        RST_N_IN,
	input  wire logic        WB_CYC_IN,
	input  wire logic        WB_STB_IN,
	input  wire logic        WB_WE_IN,
	input  wire logic [7:0]  WB_ADR_IN,
	input  wire logic [3:0]  WB_SEL_IN,
	input  wire logic [31:0] WB_DAT_IN,
	output logic      [31:0] WB_DAT_OUT,
	output logic             WB_ACK_OUT,
	input  wire logic        KP_PRESENT_IN,
	input  wire logic [15:0] KP_ID_IN,
	input  wire logic [15:0] KP_OFF_DAYS_IN,
	input  wire logic        KP_WR_IN,
	input  wire logic [2:0]  KP_IDX_IN,
	input  wire logic [15:0] KP_DATA_IN,
	output logic             CAL_WARN_OUT,
	output logic             TIME_CORR_WARN_OUT,
	output logic             REFRESH_TIMEOUT_WARN_OUT,
	output logic             IRQ_OUT
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic             pend;
		logic             ack;
		logic [31:0]      dat;
		logic             ignore;
		logic [23:0]      opa;
		logic [23:0]      opb;
		logic [23:0]      opc;
		logic [31:0]      result;
		logic             rng_err;
		logic             active;
		logic [IRQ_W-1:0] sts;
		logic [IRQ_W-1:0] msk;
		logic             irq;
		logic             seen;
		logic             chk_done;
		logic [15:0]      kp_id;
		logic [6:0]       bad;
		logic [23:0]      now;
		logic             pend_corr;
		logic             pend_rt;
		logic             warn_corr;
		logic             warn_rt;
		logic             cal_warn;
		logic [31:0]      tick_cnt;
		logic [31:0]      start_cnt;
		logic [31:0]      abs_cnt;
	} cs_state_t;

	cs_state_t        s_q, s_d;
	logic [15:0]      mem_rd;
	logic             bus_req;
	logic             bus_wr;
	logic             tick;
	logic             wr_cmd;
	logic [31:0]      flags;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		merge = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) merge[8*b +: 8] = nw[8*b +: 8];
		end
	endfunction : merge

	function automatic logic time_ok(input logic [23:0] t);
		time_ok = cs_word_ok(IDX_HOUR, {8'h00, t[T_HOUR_LSB +: 8]}) &&
			cs_word_ok(IDX_MINUTE, {8'h00, t[T_MIN_LSB +: 8]}) &&
			cs_word_ok(IDX_SECOND, {8'h00, t[T_SEC_LSB +: 8]});
	endfunction : time_ok

	// Calendar words live in the store; the keypad is their only writer
	cs_word_store u_store (
		.clk_in      (CLK_IN),
		.rst_n_in    (RST_N_IN),
		.wr_en_in    (KP_WR_IN),
		.wr_idx_in   (KP_IDX_IN),
		.wr_data_in  (KP_DATA_IN),
		.rd_idx_in   (WB_ADR_IN[4:2]),
		.rd_data_out (mem_rd)
	);

	assign bus_req = WB_CYC_IN & WB_STB_IN;
	assign bus_wr  = bus_req & WB_WE_IN & s_q.ack;
	assign tick    = s_q.tick_cnt == TICK_CYC - 1;
	assign wr_cmd  = bus_wr && (WB_ADR_IN == ADR_CMD) && WB_SEL_IN[0];

	always_comb begin
		flags = '0;
		flags[FLG_TIME_ERR]     = |s_q.bad;
		flags[FLG_WARN_PRESENT] = s_q.warn_corr | s_q.warn_rt;
		flags[FLG_RANGE_ERR]    = s_q.rng_err;
		flags[FLG_ACTIVE]       = s_q.active;
		flags[FLG_CORR]         = s_q.warn_corr;
		flags[FLG_TIMEOUT]      = s_q.warn_rt;
		flags[FLG_PRESENT]      = KP_PRESENT_IN;
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic [IRQ_W-1:0] set;
		logic [IRQ_W-1:0] clr;
		logic [7:0]       hs;
		logic [7:0]       hm;
		logic [7:0]       hh;
		logic             cy;
		logic             cy2;
		logic             bad_op;
		logic [31:0]      mrg;
		set    = '0;
		clr    = '0;
		hs     = '0;
		hm     = '0;
		hh     = '0;
		cy     = 1'b0;
		cy2    = 1'b0;
		bad_op = 1'b0;
		mrg    = '0;
		s_d    = s_q;
		s_d.ack = 1'b0;

		// Bus: request taken, then data registered with ack one cycle later
		if (bus_req && !s_q.pend && !s_q.ack) begin
			s_d.pend = 1'b1;
		end
		if (s_q.pend) begin
			s_d.pend = 1'b0;
			s_d.ack  = 1'b1;
			unique case (WB_ADR_IN)
				ADR_YEAR, ADR_WEEKDAY, ADR_MONTH, ADR_DAY,
				ADR_HOUR, ADR_MINUTE, ADR_SECOND: s_d.dat = {16'h0000, mem_rd};
				ADR_FLAGS:   s_d.dat = flags;
				ADR_CTRL:    s_d.dat = {31'h0000_0000, s_q.ignore};
				ADR_OPA:     s_d.dat = {8'h00, s_q.opa};
				ADR_OPB:     s_d.dat = {8'h00, s_q.opb};
				ADR_OPC:     s_d.dat = {8'h00, s_q.opc};
				ADR_RESULT:  s_d.dat = s_q.result;
				ADR_IRQ_STS: s_d.dat = {28'h000_0000, s_q.sts};
				ADR_IRQ_MSK: s_d.dat = {28'h000_0000, s_q.msk};
				default:     s_d.dat = 32'h0000_0000;
			endcase
		end

		// Bus writes take effect at the acknowledging edge
		if (bus_wr) begin
			// Old value first, so unselected bytes keep their contents
			unique case (WB_ADR_IN)
				ADR_CTRL:    mrg = {31'h0000_0000, s_q.ignore};
				ADR_OPA:     mrg = {8'h00, s_q.opa};
				ADR_OPB:     mrg = {8'h00, s_q.opb};
				ADR_OPC:     mrg = {8'h00, s_q.opc};
				ADR_IRQ_MSK: mrg = {28'h000_0000, s_q.msk};
				default:     mrg = 32'h0000_0000;
			endcase
			mrg = merge(mrg, WB_DAT_IN, WB_SEL_IN);
			unique case (WB_ADR_IN)
				ADR_CTRL:    s_d.ignore = mrg[CTRL_IGNORE];
				ADR_OPA:     s_d.opa = mrg[23:0];
				ADR_OPB:     s_d.opb = mrg[23:0];
				ADR_OPC:     s_d.opc = mrg[23:0];
				ADR_IRQ_STS: clr = mrg[IRQ_W-1:0];
				ADR_IRQ_MSK: s_d.msk = mrg[IRQ_W-1:0];
				default: ;
			endcase
		end

		// Time operations on packed {hour, minute, second}
		if (wr_cmd) begin
			unique case (WB_DAT_IN[2:0])
				OP_CMP: begin
					bad_op = !time_ok(s_q.opa) || !time_ok(s_q.opb);
					s_d.result = {29'h0000_0000, s_q.opa > s_q.opb, s_q.opa == s_q.opb,
						s_q.opa < s_q.opb};
				end
				OP_ZCP: begin
					bad_op = !time_ok(s_q.opa) || !time_ok(s_q.opb) || !time_ok(s_q.opc);
					s_d.result = {29'h0000_0000, s_q.opc > s_q.opb,
						(s_q.opc >= s_q.opa) && (s_q.opc <= s_q.opb), s_q.opc < s_q.opa};
				end
				OP_ADD: begin
					bad_op = !time_ok(s_q.opa) || !time_ok(s_q.opb);
					hs  = s_q.opa[T_SEC_LSB +: 8] + s_q.opb[T_SEC_LSB +: 8];
					cy  = hs >= SEC_WRAP;
					hs  = cy ? hs - SEC_WRAP : hs;
					hm  = s_q.opa[T_MIN_LSB +: 8] + s_q.opb[T_MIN_LSB +: 8] + {7'h00, cy};
					cy2 = hm >= SEC_WRAP;
					hm  = cy2 ? hm - SEC_WRAP : hm;
					hh  = s_q.opa[T_HOUR_LSB +: 8] + s_q.opb[T_HOUR_LSB +: 8] + {7'h00, cy2};
					hh  = (hh >= HOUR_WRAP) ? hh - HOUR_WRAP : hh;
					s_d.result = {8'h00, hh, hm, hs};
				end
				OP_SUB: begin
					bad_op = !time_ok(s_q.opa) || !time_ok(s_q.opb);
					cy  = s_q.opa[T_SEC_LSB +: 8] < s_q.opb[T_SEC_LSB +: 8];
					hs  = s_q.opa[T_SEC_LSB +: 8] - s_q.opb[T_SEC_LSB +: 8] + (cy ? SEC_WRAP : 8'h00);
					hm  = s_q.opb[T_MIN_LSB +: 8] + {7'h00, cy};
					cy2 = s_q.opa[T_MIN_LSB +: 8] < hm;
					hm  = s_q.opa[T_MIN_LSB +: 8] - hm + (cy2 ? SEC_WRAP : 8'h00);
					hh  = s_q.opb[T_HOUR_LSB +: 8] + {7'h00, cy2};
					hh  = (s_q.opa[T_HOUR_LSB +: 8] < hh) ?
						s_q.opa[T_HOUR_LSB +: 8] + HOUR_WRAP - hh : s_q.opa[T_HOUR_LSB +: 8] - hh;
					s_d.result = {8'h00, hh, hm, hs};
				end
				OP_READ: begin
					s_d.result = {8'h00, s_q.now};
				end
				default: ;
			endcase
			if (WB_DAT_IN[2:0] inside {OP_CMP, OP_ZCP, OP_ADD, OP_SUB, OP_READ}) begin
				s_d.active  = 1'b1;
				s_d.rng_err = bad_op;
				if (bad_op) s_d.result = 32'h0000_0000;
				set[IRQ_DONE]  = 1'b1;
				set[IRQ_RANGE] = bad_op;
			end
		end

		// Keypad attach and exchange
		if (KP_PRESENT_IN && !s_q.seen) begin
			s_d.seen  = 1'b1;
			s_d.kp_id = KP_ID_IN;
		end else if (KP_PRESENT_IN && (KP_ID_IN != s_q.kp_id)) begin
			s_d.kp_id = KP_ID_IN;
			if (s_q.active) s_d.pend_corr = 1'b1;
		end

		// Keypad time words: validity and startup check
		if (KP_WR_IN && (KP_IDX_IN != 3'h7)) begin
			s_d.bad[KP_IDX_IN] = !cs_word_ok(KP_IDX_IN, KP_DATA_IN);
			if (KP_IDX_IN == IDX_HOUR) s_d.now[T_HOUR_LSB +: 8] = KP_DATA_IN[7:0];
			if (KP_IDX_IN == IDX_MINUTE) s_d.now[T_MIN_LSB +: 8] = KP_DATA_IN[7:0];
			if (KP_IDX_IN == IDX_SECOND) s_d.now[T_SEC_LSB +: 8] = KP_DATA_IN[7:0];
			if ((KP_IDX_IN == IDX_SECOND) && !s_q.chk_done) begin
				s_d.chk_done = 1'b1;
				if ((KP_OFF_DAYS_IN > LAPSE_LIMIT_DAYS) || (|s_d.bad)) begin
					s_d.pend_corr = 1'b1;
				end
			end
		end

		// Millisecond divider and supervision timers
		s_d.tick_cnt = tick ? 32'h0000_0000 : s_q.tick_cnt + 32'h0000_0001;
		if (tick && !s_q.seen && (s_q.start_cnt < STARTUP_LIMIT)) begin
			s_d.start_cnt = s_q.start_cnt + 32'h0000_0001;
			if (s_d.start_cnt == STARTUP_LIMIT) s_d.pend_rt = 1'b1;
		end
		// Absence counts only while the calendar runs normally
		if (KP_PRESENT_IN || !s_q.active || !s_q.seen || s_q.warn_rt) begin
			s_d.abs_cnt = 32'h0000_0000;
		end else if (tick && (s_q.abs_cnt < ABSENT_LIMIT)) begin
			s_d.abs_cnt = s_q.abs_cnt + 32'h0000_0001;
			if (s_d.abs_cnt == ABSENT_LIMIT) s_d.pend_rt = 1'b1;
		end

		// Warnings: shown once active, the two flags cleared only by reset; CAL_WARN_OUT drops while ignore is set
		s_d.warn_corr = s_q.warn_corr | (s_d.pend_corr & s_d.active);
		s_d.warn_rt   = s_q.warn_rt | (s_d.pend_rt & s_d.active);
		s_d.cal_warn  = (s_d.warn_corr | s_d.warn_rt) & ~s_d.ignore;
		set[IRQ_CORR]    = s_d.warn_corr & ~s_q.warn_corr;
		set[IRQ_TIMEOUT] = s_d.warn_rt & ~s_q.warn_rt;

		// Set wins over a write-one clear in the same cycle
		s_d.sts = (s_q.sts & ~clr) | set;
		s_d.irq = |(s_d.sts & s_d.msk);
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign WB_DAT_OUT               = s_q.dat;
	assign WB_ACK_OUT               = s_q.ack;
	assign CAL_WARN_OUT             = s_q.cal_warn;
	assign TIME_CORR_WARN_OUT       = s_q.warn_corr;
	assign REFRESH_TIMEOUT_WARN_OUT = s_q.warn_rt;
	assign IRQ_OUT                  = s_q.irq;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);

	sequence req_taken_s;
		bus_req && !s_q.pend && !s_q.ack;
	endsequence
	sequence answer_s;
		s_q.pend ##1 (s_q.ack && !s_q.pend) ##1 !s_q.ack;
	endsequence

	bus_answer_a: assert property (req_taken_s |=> answer_s)
		else $error("ack not two cycles after request");
	warn_hold_a: assert property (s_q.warn_rt |=> s_q.warn_rt)
		else $error("timeout warning dropped without reset");
	corr_keep_a: assert property (s_q.warn_corr |=> s_q.warn_corr)
		else $error("correction warning cleared");
	warn_gate_a: assert property ($rose(s_q.warn_rt) || $rose(s_q.warn_corr) |-> s_q.active)
		else $error("warning raised while inactive");
	cal_warn_a: assert property (##1 CAL_WARN_OUT ==
		((s_q.warn_corr | s_q.warn_rt) & ~s_q.ignore))
		else $error("combined warning mismatch");
	range_err_a: assert property (wr_cmd && (WB_DAT_IN[2:0] == OP_ADD) && !time_ok(s_q.opa)
		|=> s_q.rng_err && s_q.sts[IRQ_RANGE])
		else $error("range error not flagged");
	activate_a: assert property ($rose(s_q.active) |-> $past(wr_cmd))
		else $error("activated without a time operation");
	exchange_a: assert property (s_q.active && s_q.seen && KP_PRESENT_IN
		&& (KP_ID_IN != s_q.kp_id) |=> s_q.pend_corr ##1 s_q.warn_corr)
		else $error("keypad swap not flagged");
	startup_a: assert property (tick && !s_q.seen && (s_q.start_cnt == STARTUP_LIMIT - 1)
		|=> s_q.pend_rt)
		else $error("startup timeout missing");
	absent_a: assert property (s_q.abs_cnt <= ABSENT_LIMIT)
		else $error("absence counter overran");
	time_err_a: assert property (KP_WR_IN && !cs_word_ok(KP_IDX_IN, KP_DATA_IN)
		&& (KP_IDX_IN != 3'h7) |=> s_q.bad != 7'h00)
		else $error("bad keypad time not flagged");
	irq_level_a: assert property (s_q.pend |=> IRQ_OUT == |(s_q.sts & s_q.msk))
		else $error("interrupt level mismatch");

endmodule : cs_calendar_supervision

/* cs_pkg.sv */
/*
 * Shared constants for the calendar supervision block: register map,
 * field positions, calendar limits, operation codes and timing.
 * Assumes a single 200 MHz clock and a 32-bit classic Wishbone slave.
 */
package cs_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 200_000_000;
	localparam int unsigned TICK_HZ         = 1000;
	localparam int unsigned TICK_CYCLES     = CLK_HZ / TICK_HZ;
	localparam int unsigned STARTUP_WAIT_S  = 10;
	localparam int unsigned ABSENT_WAIT_MIN = 1;
	localparam int unsigned SEC_PER_MIN     = 60;
	localparam int unsigned STARTUP_TICKS   = STARTUP_WAIT_S * TICK_HZ;
	localparam int unsigned ABSENT_TICKS    = ABSENT_WAIT_MIN * SEC_PER_MIN * TICK_HZ;
	localparam logic [15:0] LAPSE_LIMIT_DAYS = 16'h0007;

	// ------------------------------------------------------------
	// Calendar word store
	// ------------------------------------------------------------
	localparam int unsigned CAL_DEPTH  = 8;
	localparam int unsigned CAL_WORD_W = 16;
	localparam logic [2:0]  IDX_YEAR    = 3'h0;
	localparam logic [2:0]  IDX_WEEKDAY = 3'h1;
	localparam logic [2:0]  IDX_MONTH   = 3'h2;
	localparam logic [2:0]  IDX_DAY     = 3'h3;
	localparam logic [2:0]  IDX_HOUR    = 3'h4;
	localparam logic [2:0]  IDX_MINUTE  = 3'h5;
	localparam logic [2:0]  IDX_SECOND  = 3'h6;

	// Limits, year 2000..2099
	localparam logic [15:0] YEAR_MIN   = 16'h07D0;
	localparam logic [15:0] YEAR_MAX   = 16'h0833;
	localparam logic [15:0] ONE_MIN    = 16'h0001;
	localparam logic [15:0] WDAY_MAX   = 16'h0007;
	localparam logic [15:0] MONTH_MAX  = 16'h000C;
	localparam logic [15:0] DAY_MAX    = 16'h001F;
	localparam logic [15:0] HOUR_MAX   = 16'h0017;
	localparam logic [15:0] MINSEC_MAX = 16'h003B;
	localparam logic [7:0]  SEC_WRAP   = 8'h3C;
	localparam logic [7:0]  HOUR_WRAP  = 8'h18;

	// Packed time operand {hour, minute, second}
	localparam int unsigned T_HOUR_LSB = 16;
	localparam int unsigned T_MIN_LSB  = 8;
	localparam int unsigned T_SEC_LSB  = 0;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] ADR_YEAR    = 8'h00;
	localparam logic [7:0] ADR_WEEKDAY = 8'h04;
	localparam logic [7:0] ADR_MONTH   = 8'h08;
	localparam logic [7:0] ADR_DAY     = 8'h0C;
	localparam logic [7:0] ADR_HOUR    = 8'h10;
	localparam logic [7:0] ADR_MINUTE  = 8'h14;
	localparam logic [7:0] ADR_SECOND  = 8'h18;
	localparam logic [7:0] ADR_FLAGS   = 8'h1C;
	localparam logic [7:0] ADR_CTRL    = 8'h20;
	localparam logic [7:0] ADR_OPA     = 8'h24;
	localparam logic [7:0] ADR_OPB     = 8'h28;
	localparam logic [7:0] ADR_OPC     = 8'h2C;
	localparam logic [7:0] ADR_CMD     = 8'h30;
	localparam logic [7:0] ADR_RESULT  = 8'h34;
	localparam logic [7:0] ADR_IRQ_STS = 8'h38;
	localparam logic [7:0] ADR_IRQ_MSK = 8'h3C;

	// Flag register bits and the control register bit
	localparam int unsigned FLG_TIME_ERR     = 0;
	localparam int unsigned FLG_WARN_PRESENT = 1;
	localparam int unsigned FLG_RANGE_ERR    = 2;
	localparam int unsigned FLG_ACTIVE       = 3;
	localparam int unsigned FLG_CORR         = 4;
	localparam int unsigned FLG_TIMEOUT      = 5;
	localparam int unsigned FLG_PRESENT      = 6;
	localparam int unsigned CTRL_IGNORE      = 0;

	// Interrupt status and mask bits
	localparam int unsigned IRQ_W       = 4;
	localparam int unsigned IRQ_CORR    = 0;
	localparam int unsigned IRQ_TIMEOUT = 1;
	localparam int unsigned IRQ_RANGE   = 2;
	localparam int unsigned IRQ_DONE    = 3;

	// Operation codes
	localparam logic [2:0] OP_CMP  = 3'h1;
	localparam logic [2:0] OP_ZCP  = 3'h2;
	localparam logic [2:0] OP_ADD  = 3'h3;
	localparam logic [2:0] OP_SUB  = 3'h4;
	localparam logic [2:0] OP_READ = 3'h5;

	// ------------------------------------------------------------
	// Range check of one calendar word
	// ------------------------------------------------------------
	function automatic logic cs_word_ok(input logic [2:0] idx, input logic [15:0] v);
		unique case (idx)
			IDX_YEAR:    cs_word_ok = (v >= YEAR_MIN) && (v <= YEAR_MAX);
			IDX_WEEKDAY: cs_word_ok = (v >= ONE_MIN) && (v <= WDAY_MAX);
			IDX_MONTH:   cs_word_ok = (v >= ONE_MIN) && (v <= MONTH_MAX);
			IDX_DAY:     cs_word_ok = (v >= ONE_MIN) && (v <= DAY_MAX);
			IDX_HOUR:    cs_word_ok = v <= HOUR_MAX;
			IDX_MINUTE:  cs_word_ok = v <= MINSEC_MAX;
			IDX_SECOND:  cs_word_ok = v <= MINSEC_MAX;
			default:     cs_word_ok = 1'b0;
		endcase
	endfunction : cs_word_ok

endpackage : cs_pkg

/* cs_word_store.sv */
/*
 * Calendar word store: eight 16-bit words, one write port fed by the
 * keypad, one read port whose data come out of a register.
 * Assumes the read index is held stable for a cycle before use.
 */
`timescale 1ns/1ps
module cs_word_store
	import cs_pkg::*;
(
	input  wire logic                  clk_in,
	input  wire logic                  rst_n_in,
	input  wire logic                  wr_en_in,
	input  wire logic [2:0]            wr_idx_in,
	input  wire logic [CAL_WORD_W-1:0] wr_data_in,
	input  wire logic [2:0]            rd_idx_in,
	output logic      [CAL_WORD_W-1:0] rd_data_out
);

	typedef struct packed {
		logic [CAL_DEPTH-1:0][CAL_WORD_W-1:0] words;
		logic [CAL_WORD_W-1:0]                rd;
	} cs_store_t;

	cs_store_t m_q, m_d;

	always_comb begin
		m_d = m_q;
		if (wr_en_in) begin
			m_d.words[wr_idx_in] = wr_data_in;
		end
		m_d.rd = m_q.words[rd_idx_in];
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			m_q <= '0;
		end else begin
			m_q <= m_d;
		end
	end

	assign rd_data_out = m_q.rd;

endmodule : cs_word_store

/* cs_keypad_model.sv */
/*
 * Keypad model: calendar clock source with an identity and a lapse count.
 * Assumes the bench drives attach, identity and lapse just after clock edges.
 */
`timescale 1ns/1ps
module cs_keypad_model
	import cs_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        attach_in,
	input  wire logic [15:0] id_in,
	input  wire logic [15:0] off_in,
	output logic             present_out,
	output logic      [15:0] id_out,
	output logic      [15:0] off_out,
	output logic             wr_out,
	output logic      [2:0]  idx_out,
	output logic      [15:0] data_out
);
	// ------------------------------------------------------------
	// Pins
	// ------------------------------------------------------------
	// Detached lines float: show the inverse, never a stale value
	assign present_out = attach_in;
	assign id_out      = attach_in ? id_in : ~id_in;
	assign off_out     = attach_in ? off_in : ~off_in;

	initial begin
		wr_out   = 1'b0;
		idx_out  = 3'h0;
		data_out = 16'h0000;
	end

	// Words go out only while attached; no clock source otherwise
	task automatic word(input logic [2:0] i, input logic [15:0] v);
		if (attach_in) begin
			@(posedge clk_in);
			wr_out   <= 1'b1;
			idx_out  <= i;
			data_out <= v;
			@(posedge clk_in);
			wr_out   <= 1'b0;
			data_out <= ~v;
		end
	endtask : word

	task automatic send(input logic [15:0] w [7]);
		for (int i = 0; i < 7; i++) word(3'(i), w[i]);
	endtask : send
endmodule : cs_keypad_model

/* tb.sv */
/*
 * Self-checking bench for the calendar supervision block.
 * Assumes short tick and wait parameters so timeouts fit a short run.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module tb
	import cs_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic        attach = 1'b1;
	logic [15:0] kid = 16'h0A0A;
	logic [15:0] koff = 16'h0000;
	logic [31:0] rdat, rd, a, b, c;
	logic [31:0] lf = 32'h0000_213F;
	logic        ack, kpres, kwr, warn, corr, tmo, irq;
	logic [2:0]  kidx;
	logic [15:0] kid_p, koff_p, kdat;
	int          sa, sb, sc;
	int          error_cnt = 0;
	int          samples_checked = 0;
	logic [15:0] w [7] = '{16'h0833, 16'h0007, 16'h000C, 16'h001F, 16'h0017, 16'h003B, 16'h003B};

	initial forever #2.5 clk = ~clk;

	cs_calendar_supervision #(.TICK_CYC(4), .STARTUP_LIMIT(5), .ABSENT_LIMIT(5))
	u_cs_calendar_supervision (.CLK_IN(clk), .RST_N_IN(rst_n), .WB_CYC_IN(cyc),
		.WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
		.WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .KP_PRESENT_IN(kpres), .KP_ID_IN(kid_p),
		.KP_OFF_DAYS_IN(koff_p), .KP_WR_IN(kwr), .KP_IDX_IN(kidx), .KP_DATA_IN(kdat),
		.CAL_WARN_OUT(warn), .TIME_CORR_WARN_OUT(corr), .REFRESH_TIMEOUT_WARN_OUT(tmo),
		.IRQ_OUT(irq));

	cs_keypad_model kp (.clk_in(clk), .attach_in(attach), .id_in(kid), .off_in(koff),
		.present_out(kpres), .id_out(kid_p), .off_out(koff_p), .wr_out(kwr),
		.idx_out(kidx), .data_out(kdat));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nx

	function automatic int ts(input logic [31:0] p);
		return p[23:16] * 3600 + p[15:8] * 60 + p[7:0];
	endfunction : ts

	// Sub may go negative: fold into one day
	function automatic logic [23:0] tp(input int s);
		s = (s % 86400 + 86400) % 86400;
		return {8'(s / 3600), 8'(s / 60 % 60), 8'(s % 60)};
	endfunction : tp

	task automatic rt(output logic [31:0] v);
		v = {8'h00, 8'(lf % 24), 8'(lf[15:8] % 60), 8'(lf[23:16] % 60)};
		lf = nx(lf);
	endtask : rt

	task automatic rst();
		rst_n <= 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
	endtask : rst

	task automatic wb(input logic w_, input logic [7:0] ad, input logic [31:0] d);
		int n = 0;
		@(posedge clk);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w_;
		adr  <= ad;
		wdat <= d;
		sel  <= 4'hF;
		// The wait ends on ack and has no limit of its own; only the watchdog ends a hung one; the answer edge is then checked
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1);
		`CHK(n, 3)
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask : wb

	task automatic op(input logic [2:0] cd, input logic [31:0] x, y, z);
		wb(1'b1, ADR_OPA, x);
		wb(1'b1, ADR_OPB, y);
		wb(1'b1, ADR_OPC, z);
		wb(1'b1, ADR_CMD, {29'h0, cd});
		wb(1'b0, ADR_RESULT, 32'h0);
	endtask : op

	task automatic report_and_stop();
		if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : report_and_stop

	initial begin
		#200000;
		error_cnt++;
		report_and_stop();
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		rst();
		kp.send(w);
		for (int i = 0; i < 7; i++) begin
			wb(1'b0, 8'(i * 4), 32'h0);
			`CHK(rd[15:0], w[i])
		end
		wb(1'b1, ADR_YEAR, 32'h0000_1234);
		wb(1'b0, ADR_YEAR, 32'h0);
		`CHK(rd[15:0], w[0])
		wb(1'b0, 8'h40, 32'h0);
		`CHK(rd, 32'h0)
		wb(1'b0, ADR_FLAGS, 32'h0);
		`CHK(rd[3:0], 4'h0)
		kp.word(3'h6, 16'h003C);
		wb(1'b0, ADR_FLAGS, 32'h0);
		`CHK(rd[FLG_TIME_ERR], 1'b1)
		kp.word(3'h6, 16'h003B);
		wb(1'b0, ADR_FLAGS, 32'h0);
		`CHK(rd[FLG_TIME_ERR], 1'b0)
		for (int i = 0; i < 6; i++) begin
			rt(a);
			rt(b);
			rt(c);
			sa = ts(a);
			sb = ts(b);
			sc = ts(c);
			op(OP_CMP, a, b, c);
			`CHK(rd[2:0], {sa > sb, sa == sb, sa < sb})
			op(OP_ZCP, a, b, c);
			`CHK(rd[2:0], {sc > sb, sa <= sc && sc <= sb, sc < sa})
			op(OP_ADD, a, b, c);
			`CHK(rd[23:0], tp(sa + sb))
			op(OP_SUB, a, b, c);
			`CHK(rd[23:0], tp(sa - sb))
		end
		wb(1'b0, ADR_FLAGS, 32'h0);
		`CHK(rd[FLG_ACTIVE], 1'b1)
		op(OP_READ, 32'h0, 32'h0, 32'h0);
		wb(1'b0, ADR_IRQ_STS, 32'h0);
		`CHK(rd[IRQ_DONE], 1'b1)
		wb(1'b1, ADR_IRQ_STS, 32'h0000_000F);
		wb(1'b1, ADR_IRQ_MSK, 32'h0000_0000);
		op(OP_ZCP, 32'h0, 32'h0, 32'h0018_0000);
		`CHK(irq, 1'b0)
		wb(1'b1, ADR_IRQ_MSK, 32'h0000_0004);
		op(OP_ADD, 32'h0000_003C, 32'h0, 32'h0);
		`CHK(rd, 32'h0)
		wb(1'b0, ADR_FLAGS, 32'h0);
		`CHK({rd[FLG_RANGE_ERR], irq}, 2'b11)
		wb(1'b1, ADR_IRQ_STS, 32'h0000_0004);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		op(OP_SUB, 32'h0017_3B3B, 32'h0, 32'h0);
		`CHK(rd[23:0], 24'h17_3B3B)
		wb(1'b0, ADR_FLAGS, 32'h0);
		`CHK(rd[FLG_RANGE_ERR], 1'b0)
		`CHK(corr, 1'b0)
		kid <= 16'h0B0B;
		repeat (4) @(posedge clk);
		`CHK({corr, warn}, 2'b11)
		wb(1'b0, ADR_FLAGS, 32'h0);
		`CHK(rd[FLG_WARN_PRESENT], 1'b1)
		wb(1'b1, ADR_CTRL, 32'h0000_0001);
		repeat (2) @(posedge clk);
		`CHK({corr, warn}, 2'b10)
		attach <= 1'b0;
		repeat (8) @(posedge clk);
		`CHK(tmo, 1'b0)
		repeat (40) @(posedge clk);
		`CHK(tmo, 1'b1)
		wb(1'b1, ADR_IRQ_STS, 32'h0000_000F);
		op(OP_ADD, 32'h0000_0001, 32'h0000_0002, 32'h0);
		`CHK({rd[23:0], corr, tmo}, 26'h000_000F)
		// Lapse at the limit with keypad present, then lapse over it with keypad missing at power-up
		for (int k = 0; k < 2; k++) begin
			attach <= (k == 0);
			koff   <= 16'(7 + k);
			kid    <= 16'h0A0A;
			rst();
			`CHK({corr, tmo, warn}, 3'b000)
			if (k == 1) repeat (40) @(posedge clk);
			attach <= 1'b1;
			@(posedge clk);
			kp.send(w);
			repeat (4) @(posedge clk);
			`CHK({corr, tmo}, 2'b00)
			op(OP_READ, 32'h0, 32'h0, 32'h0);
			repeat (2) @(posedge clk);
			`CHK(corr, 1'(k))
			`CHK(tmo, 1'(k))
		end
		report_and_stop();
	end
endmodule : tb
